// *** pkg/aab_params.svh ***
// constants for the accumulator alu datapath
`ifndef AAB_PARAMS_SVH
`define AAB_PARAMS_SVH
`define AAB_DATA_W 8
`define AAB_ADDR_W 7
`define AAB_BIT_W 3
`define AAB_W_RESET 8'h00
`define AAB_NIBBLE_MSB 3
`endif

// *** pkg/aab_pkg.sv ***
// types for the accumulator alu datapath
package aab_pkg;
  typedef enum logic [2:0] {
    AAB_OP_ADD_LIT = 3'h0,
    AAB_OP_ADD_FILE = 3'h1,
    AAB_OP_AND_LIT = 3'h2,
    AAB_OP_AND_FILE = 3'h3,
    AAB_OP_BIT_CLR = 3'h4,
    AAB_OP_BIT_SET = 3'h5,
    AAB_OP_SKIP_CLR = 3'h6,
    AAB_OP_SKIP_SET = 3'h7
  } aab_op_t;
  typedef enum logic [0:0] {
    AAB_ST_RUN = 1'b0,
    AAB_ST_NOP = 1'b1
  } aab_state_t;
endpackage

// *** rtl/aab_adder.sv ***
// 8-bit adder with carry out of bit 3 and bit 7
`timescale 1ns/1ps
`include "aab_params.svh"
module aab_adder #(
  parameter int WIDTH = `AAB_DATA_W
) (
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] b_in,
  output logic [WIDTH-1:0] sum_out,
  output logic carry_out,
  output logic digit_carry_out
);
  logic [4:0] low_sum;
  logic [WIDTH:0] full_sum;
  always_comb begin
    low_sum = {1'b0, a_in[`AAB_NIBBLE_MSB:0]} + {1'b0, b_in[`AAB_NIBBLE_MSB:0]};
    full_sum = {1'b0, a_in} + {1'b0, b_in};
    sum_out = full_sum[WIDTH-1:0];
    carry_out = full_sum[WIDTH]; // [RULE9]
    digit_carry_out = low_sum[4]; // [RULE9]
  end
endmodule

// *** rtl/aab_core.sv ***
// execution datapath for add, and, bit and skip operations
`timescale 1ns/1ps
`include "aab_params.svh"
// Functional notes
// [RULE1] add literal: w plus literal into w, carry, digit carry, zero updated
// [RULE2] add file: w plus file, result to w if dest 0 else file
// [RULE3] and literal: w and literal into w, only zero updated
// [RULE4] and file: w and file, routed by dest, only zero updated
// [RULE5] bit clear: selected file bit forced to 0, flags untouched
// [RULE6] bit set: selected file bit forced to 1, flags untouched
// [RULE7] skip if clear: bit 0 discards next instruction as a nop cycle
// [RULE8] skip if set: bit 1 discards next instruction; tests change no flag
// [RULE9] zero on zero result, carry out of bit 7, digit carry bit 3
// [RULE10] non-skipping operations take one cycle; file addresses are 7 bits
module aab_core
  import aab_pkg::*;
#(
  parameter int DATA_W = `AAB_DATA_W,
  parameter int ADDR_W = `AAB_ADDR_W
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic exec_valid_in,
  input wire aab_op_t op_in,
  input wire logic [DATA_W-1:0] literal_in,
  input wire logic [ADDR_W-1:0] file_addr_in,
  input wire logic dest_file_in,
  input wire logic [`AAB_BIT_W-1:0] bit_sel_in,
  input wire logic [DATA_W-1:0] file_rdata_in,
  output logic [ADDR_W-1:0] file_raddr_out,
  output logic file_we_out,
  output logic [ADDR_W-1:0] file_waddr_out,
  output logic [DATA_W-1:0] file_wdata_out,
  output logic [DATA_W-1:0] acc_out,
  output logic carry_flag_out,
  output logic digit_carry_flag_out,
  output logic zero_flag_out,
  output logic nop_cycle_out
);
  // ==========================================================
  // state
  aab_state_t state;
  aab_state_t next_state;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] next_acc;
  logic carry;
  logic next_carry;
  logic digit_carry;
  logic next_digit_carry;
  logic zero;
  logic next_zero;
  logic we;
  logic next_we;
  logic [ADDR_W-1:0] waddr;
  logic [ADDR_W-1:0] next_waddr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] next_wdata;
  logic [DATA_W-1:0] add_b;
  logic [DATA_W-1:0] add_sum;
  logic add_c;
  logic add_digit_carry;
  logic [DATA_W-1:0] and_res;
  logic [DATA_W-1:0] bit_hit;
  logic [DATA_W-1:0] clr_res;
  logic [DATA_W-1:0] set_res;
  logic test_bit;
  logic skip_taken;
  logic running;

  // ==========================================================
  // datapath
  // file read is combinational so every operation fits one cycle
  assign file_raddr_out = file_addr_in; // [RULE10]
  assign running = exec_valid_in && (state == AAB_ST_RUN);
  assign add_b = (op_in == AAB_OP_ADD_LIT) ? literal_in : file_rdata_in;
  assign and_res = acc & ((op_in == AAB_OP_AND_LIT) ? literal_in : file_rdata_in);
  assign test_bit = |(file_rdata_in & bit_hit);
  assign skip_taken = ((op_in == AAB_OP_SKIP_CLR) && !test_bit) || // [RULE7]
    ((op_in == AAB_OP_SKIP_SET) && test_bit); // [RULE8]

  aab_adder #(
    .WIDTH(DATA_W)
  ) u_adder (
    .a_in(acc),
    .b_in(add_b),
    .sum_out(add_sum),
    .carry_out(add_c),
    .digit_carry_out(add_digit_carry)
  );

  // ==========================================================
  // bit operations
  // a decoded one-hot slice per bit avoids a variable shifter
  generate
    for (genvar i = 0; i < DATA_W; i++) begin : g_bit
      assign bit_hit[i] = (int'(bit_sel_in) == i);
      assign clr_res[i] = file_rdata_in[i] & ~bit_hit[i]; // [RULE5]
      assign set_res[i] = file_rdata_in[i] | bit_hit[i]; // [RULE6]
    end
  endgenerate

  // ==========================================================
  // next values
  always_comb begin
    next_acc = acc;
    next_carry = carry;
    next_digit_carry = digit_carry;
    next_zero = zero;
    next_we = 1'b0;
    next_waddr = waddr;
    next_wdata = wdata;
    // instruction arriving during the nop cycle is the discarded one
    if (running) begin
      case (op_in)
        AAB_OP_ADD_LIT: begin
          next_acc = add_sum; // [RULE1]
          next_carry = add_c;
          next_digit_carry = add_digit_carry;
          next_zero = (add_sum == '0); // [RULE9]
        end
        AAB_OP_ADD_FILE: begin
          next_carry = add_c; // [RULE2]
          next_digit_carry = add_digit_carry;
          next_zero = (add_sum == '0);
          if (dest_file_in) begin
            next_we = 1'b1;
            next_waddr = file_addr_in;
            next_wdata = add_sum;
          end else begin
            next_acc = add_sum;
          end
        end
        AAB_OP_AND_LIT: begin
          next_acc = and_res; // [RULE3]
          next_zero = (and_res == '0);
        end
        AAB_OP_AND_FILE: begin
          next_zero = (and_res == '0); // [RULE4]
          if (dest_file_in) begin
            next_we = 1'b1;
            next_waddr = file_addr_in;
            next_wdata = and_res;
          end else begin
            next_acc = and_res;
          end
        end
        AAB_OP_BIT_CLR: begin
          next_we = 1'b1; // [RULE5]
          next_waddr = file_addr_in;
          next_wdata = clr_res;
        end
        AAB_OP_BIT_SET: begin
          next_we = 1'b1; // [RULE6]
          next_waddr = file_addr_in;
          next_wdata = set_res;
        end
        default: begin
          // skips change no flag and write nothing
          next_we = 1'b0; // [RULE8]
        end
      endcase
    end
  end

  // ==========================================================
  // skip state
  // the nop waits for a valid instruction so a stalled fetch cannot
  // let the skipped one slip through
  always_comb begin
    next_state = state;
    case (state)
      AAB_ST_RUN: begin
        if (exec_valid_in && skip_taken) begin
          next_state = AAB_ST_NOP; // [RULE7]
        end
      end
      AAB_ST_NOP: begin
        if (exec_valid_in) begin
          next_state = AAB_ST_RUN; // [RULE8]
        end
      end
      default: begin
        next_state = AAB_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= AAB_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      acc <= `AAB_W_RESET;
      carry <= 1'b0;
      digit_carry <= 1'b0;
      zero <= 1'b0;
      we <= 1'b0;
      waddr <= '0;
      wdata <= '0;
    end else begin
      acc <= next_acc;
      carry <= next_carry;
      digit_carry <= next_digit_carry;
      zero <= next_zero;
      we <= next_we;
      waddr <= next_waddr;
      wdata <= next_wdata;
    end
  end

  assign acc_out = acc;
  assign carry_flag_out = carry;
  assign digit_carry_flag_out = digit_carry;
  assign zero_flag_out = zero;
  assign file_we_out = we;
  assign file_waddr_out = waddr;
  assign file_wdata_out = wdata;
  assign nop_cycle_out = (state == AAB_ST_NOP);
endmodule

// *** testbench/aab_core_props.sv ***
// concurrent checks on the alu datapath ports
`timescale 1ns/1ps
module aab_core_props
  import aab_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic exec_valid_in,
  input wire aab_op_t op_in,
  input wire logic [7:0] literal_in,
  input wire logic [6:0] file_addr_in,
  input wire logic dest_file_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] file_rdata_in,
  input wire logic file_we_out,
  input wire logic [6:0] file_waddr_out,
  input wire logic [7:0] file_wdata_out,
  input wire logic [7:0] acc_out,
  input wire logic carry_flag_out,
  input wire logic nop_cycle_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic tk;
  // taken only outside the skip nop state
  assign tk = exec_valid_in && !nop_cycle_out;
  add_lit_a: assert property (tk && op_in == AAB_OP_ADD_LIT |=>
    {carry_flag_out, acc_out} == $past({1'b0, acc_out} + {1'b0, literal_in})) else $error("bad add");
  and_lit_a: assert property (tk && op_in == AAB_OP_AND_LIT |=>
    acc_out == $past(acc_out & literal_in) && $stable(carry_flag_out)) else $error("bad and");
  file_dest_a: assert property (tk && op_in inside {AAB_OP_ADD_FILE, AAB_OP_AND_FILE}
    && dest_file_in |=> file_we_out && file_waddr_out == $past(file_addr_in)) else $error("bad dest");
  bit_clr_a: assert property (tk && op_in == AAB_OP_BIT_CLR |=> file_we_out &&
    file_wdata_out == $past(file_rdata_in & ~(8'h01 << bit_sel_in))) else $error("bad clear");
  bit_set_a: assert property (tk && op_in == AAB_OP_BIT_SET |=> file_we_out &&
    file_wdata_out == $past(file_rdata_in | (8'h01 << bit_sel_in))) else $error("bad set");
  skip_clr_a: assert property (tk && op_in == AAB_OP_SKIP_CLR |=>
    nop_cycle_out == !$past(file_rdata_in[bit_sel_in])) else $error("bad skip clear");
  skip_set_a: assert property (tk && op_in == AAB_OP_SKIP_SET |=>
    nop_cycle_out == $past(file_rdata_in[bit_sel_in])) else $error("bad skip set");
  nop_drop_a: assert property (nop_cycle_out && exec_valid_in |=>
    !nop_cycle_out && !file_we_out && $stable(acc_out)) else $error("bad nop");
endmodule
bind aab_core aab_core_props chk_u (.*);

// *** testbench/accumulator_alu_bit_ops_bench.sv ***
// self-checking bench for the alu datapath
`timescale 1ns/1ps
module accumulator_alu_bit_ops_bench;
  import aab_pkg::*;
  logic clk_in = 0, reset_in = 1, exec_valid_in = 0, dest_file_in = 0, v = 0;
  aab_op_t op_in = AAB_OP_ADD_LIT;
  logic [7:0] literal_in = 8'h00, file_rdata_in, acc_out, file_wdata_out, ra = 8'h00;
  logic [6:0] file_addr_in = 7'h00, file_raddr_out, file_waddr_out;
  logic [2:0] bit_sel_in = 3'h0;
  logic file_we_out, carry_flag_out, digit_carry_flag_out, zero_flag_out, nop_cycle_out;
  logic rc = 0, rd = 0, rz = 0, rn = 0;
  logic [7:0] mem [128], rm [128];
  logic [27:0] q [$];
  int err_count = 0, total_checks = 0, cyc = 0;
  always #20 clk_in = ~clk_in;
  // forward a pending write so back-to-back ops see fresh data
  assign file_rdata_in = (file_we_out && file_waddr_out == file_raddr_out) ?
    file_wdata_out : mem[file_raddr_out];
  aab_core dut_u (.*);
  always @(posedge clk_in) begin
    if (file_we_out) mem[file_waddr_out] <= file_wdata_out;
    v <= exec_valid_in;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end
  always @(negedge clk_in) if (v) begin
    total_checks++;
    if ({acc_out, carry_flag_out, digit_carry_flag_out, zero_flag_out, nop_cycle_out, file_we_out,
      file_we_out ? {file_waddr_out, file_wdata_out} : 15'h0000} !== q.pop_front()) begin
      err_count++;
      $display("[ERR] %0t result mismatch", $time);
    end
  end
  // ==========
  // reference model and driver
  task automatic run(aab_op_t op, logic [7:0] k, logic [6:0] a, logic d, logic [2:0] b);
    logic [8:0] s;
    logic [7:0] f, o, r;
    logic we;
    @(negedge clk_in);
    {exec_valid_in, op_in, literal_in, file_addr_in, dest_file_in, bit_sel_in} = {1'b1, op, k, a, d, b};
    f = rm[a];
    o = op[0] ? f : k;
    r = 8'h00;
    we = 0;
    if (rn) rn = 0;
    else begin
      case (op)
        AAB_OP_ADD_LIT, AAB_OP_ADD_FILE: begin
          s = ra + o;
          rc = s[8];
          rd = (ra[3:0] + o[3:0]) > 15;
          r = s[7:0];
        end
        AAB_OP_AND_LIT, AAB_OP_AND_FILE: r = ra & o;
        AAB_OP_BIT_CLR: r = f & ~(8'h01 << b);
        AAB_OP_BIT_SET: r = f | (8'h01 << b);
        AAB_OP_SKIP_CLR: rn = !f[b];
        default: rn = f[b];
      endcase
      if (op < 4) rz = r == 8'h00;
      we = op inside {AAB_OP_BIT_CLR, AAB_OP_BIT_SET} || (op < 4 && op[0] && d);
      if (op < 4 && !we) ra = r;
      if (we) rm[a] = r;
    end
    q.push_back({ra, rc, rd, rz, rn, we, we ? {a, r} : 15'h0000});
  endtask
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h4C84));
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'($urandom);
      rm[i] = mem[i];
    end
    repeat (6) @(negedge clk_in);
    reset_in = 0;
    run(AAB_OP_ADD_LIT, 8'hFF, 7'h00, 0, 0);
    run(AAB_OP_ADD_LIT, 8'h01, 7'h00, 0, 0);
    // few addresses so writes and reads collide
    repeat (600) run(aab_op_t'(3'($urandom)), 8'($urandom), 7'($urandom_range(3)), 1'($urandom),
      3'($urandom));
    @(negedge clk_in);
    exec_valid_in = 0;
    repeat (2) @(negedge clk_in);
    summarize();
  end
endmodule
